// *** core/uart_core.sv ***
// Purpose: Serial port with shift-register mode 0 and async modes 1-3.
// Assumes: Register port and pins synchronous to ref_clk_i.
// Notes:   Writes to the data register queue in a 16-byte FIFO.
// Contract
// - Reset clears control register to zero.
// - Pending bit 0 transmit, bit 1 receive.
// - Mode 0: receive flag after eighth bit.
// - Async: receive flag at stop bit midpoint.
// - Receive flag stays until software clears it.
// - Mode 0: transmit flag after eighth bit.
// - Async: transmit flag when stop bit begins.
// - Transmit flag stays until software clears it.
// - Bit rate clock over sixteen times divisor+1.
// - Mode 2 bit rate clock over sixteen.
// - Mode 0: data on input pin, clock out.
// - Mode 0: eight bits, least significant first.
// - Control bits 7:6 zero select mode 0.
// - Control bits 7:6 equal 01 select mode 1.
// - Data register write starts a transmission.
// - Mode 0 receive after flag clear, enable set.
// - Receive interrupt when flag and enable set.
// - Mode 1 frame: start, eight data, stop.
// - Mode 1 start and stop bits inserted.
// - Mode 1 received stop bit into ninth bit.
// - Mode 1 receive begins on low start.
// - Data read returns separate receive buffer.
// - Unread byte overwritten by the next one.
// - Mode 0 receive only flag clear, enabled.
// - Mode 2 sends and stores ninth bit.
`timescale 1ns/1ps
module uart_core (
  input  wire logic       ref_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       serial_in_pin_i,
  output logic            serial_in_pin_o,
  output logic            serial_in_pin_oe_o,
  output logic            serial_out_pin_o,
  output logic            tx_fifo_ready_o,
  output logic            rx_irq_o,
  output logic            tx_irq_o
);
  import uart_pkg::*;

  // ****************************************
  // Registers and state
  // ****************************************
  logic [7:0]   ctrl_q;
  logic [7:0]   ctrl_d;
  logic [7:0]   baud_q;
  logic         tip_q;
  logic         rip_q;
  logic [7:0]   rxbuf_q;
  logic [7:0]   pre_q;
  shift_state_t tx_state_q;
  shift_state_t tx_state_d;
  shift_state_t rx_state_q;
  shift_state_t rx_state_d;
  logic [3:0]   tx_sub_q;
  logic [3:0]   rx_sub_q;
  logic [2:0]   tx_bit_q;
  logic [2:0]   rx_bit_q;
  logic [7:0]   tx_sh_q;
  logic [7:0]   rx_sh_q;
  logic         ninth_q;
  logic         fifo_valid;
  logic [7:0]   fifo_data;
  logic         fifo_ready;
  logic         tx_line;
  logic         tx_done;
  logic         rx_done;
  logic         rb8_new;
  logic         tx_go;

  // ****************************************
  // Register decode
  // ****************************************
  mode_t mode;
  assign mode = mode_t'(ctrl_q[MODE_HI:MODE_LO]);
  wire wr_ctrl = reg_wr_i & (reg_addr_i == CTRL_ADDR);
  wire wr_pend = reg_wr_i & (reg_addr_i == PEND_ADDR);
  wire wr_data = reg_wr_i & (reg_addr_i == DATA_ADDR);
  wire wr_baud = reg_wr_i & (reg_addr_i == BAUD_ADDR);
  wire m0      = mode == MODE_SHIFT;
  wire rx_en   = ctrl_q[RE_BIT];

  wire [7:0] pend_rd = {6'h00, rip_q, tip_q};
  wire [7:0] rd_mux  = (reg_addr_i == CTRL_ADDR) ? ctrl_q :
                       (reg_addr_i == PEND_ADDR) ? pend_rd :
                       (reg_addr_i == DATA_ADDR) ? rxbuf_q :
                       (reg_addr_i == BAUD_ADDR) ? baud_q : ZERO_BYTE;

  // ****************************************
  // Baud prescaler
  // ****************************************
  // Mode 2 ignores the divisor and ticks every clock, so a bit is 16 clocks.
  wire tick = (mode == MODE_FIXED9) | (pre_q == baud_q);

  // ****************************************
  // Transmit queue
  // ****************************************
  // A write while the queue is full is dropped; software polls the ready pin.
  uart_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_tx_fifo (
    .ref_clk_i   (ref_clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (wr_data),
    .in_data_i   (reg_wdata_i),
    .in_ready_o  (fifo_ready),
    .out_valid_o (fifo_valid),
    .out_data_o  (fifo_data),
    .out_ready_i (tx_go)
  );

  // ****************************************
  // Transmitter
  // ****************************************
  // Mode 0 shares both pins with reception, so the two never overlap there.
  assign tx_go = (tx_state_q == ST_IDLE) & fifo_valid &
                 (~m0 | (rx_state_q == ST_IDLE));
  wire tx_end = tick & (tx_sub_q == SUB_LAST);

  always_comb begin
    tx_state_d = tx_state_q;
    tx_done    = 1'b0;
    unique case (tx_state_q)
      ST_IDLE: begin
        if (tx_go) begin
          tx_state_d = m0 ? ST_DATA : ST_START;
        end
      end
      ST_START: begin
        if (tx_end) begin
          tx_state_d = ST_DATA;
        end
      end
      ST_DATA: begin
        if (tx_end && tx_bit_q == LAST_DATA) begin
          tx_done = 1'b1;
          unique case (mode)
            MODE_SHIFT:  tx_state_d = ST_IDLE;
            MODE_ASYNC8: tx_state_d = ST_STOP;
            default:     begin
              tx_state_d = ST_NINTH;
              tx_done    = 1'b0;
            end
          endcase
        end
      end
      ST_NINTH: begin
        if (tx_end) begin
          tx_state_d = ST_STOP;
          tx_done    = 1'b1;
        end
      end
      ST_STOP: begin
        if (tx_end) begin
          tx_state_d = ST_IDLE;
        end
      end
      default: tx_state_d = ST_IDLE;
    endcase
  end

  always_comb begin
    unique case (tx_state_q)
      ST_START: tx_line = 1'b0;
      ST_DATA:  tx_line = tx_sh_q[0];
      ST_NINTH: tx_line = ctrl_q[TB8_BIT];
      default:  tx_line = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      tx_state_q <= ST_IDLE;
      tx_sub_q   <= 4'h0;
      tx_bit_q   <= 3'h0;
      tx_sh_q    <= ZERO_BYTE;
    end else begin
      tx_state_q <= tx_state_d;
      tx_sub_q   <= tx_go ? 4'h0 : (tick ? tx_sub_q + 4'h1 : tx_sub_q);
      if (tx_go) begin
        tx_sh_q  <= fifo_data;
        tx_bit_q <= 3'h0;
      end else if (tx_end && tx_state_q == ST_DATA) begin
        tx_sh_q  <= {1'b1, tx_sh_q[7:1]};
        tx_bit_q <= tx_bit_q + 3'h1;
      end
    end
  end

  // ****************************************
  // Receiver
  // ****************************************
  wire rx_idle  = rx_state_q == ST_IDLE;
  wire rx_go_a  = rx_idle & rx_en & ~m0 & ~serial_in_pin_i;
  wire rx_go_0  = rx_idle & rx_en & m0 & ~rip_q &
                  (tx_state_q == ST_IDLE) & ~tx_go;
  wire rx_mid   = tick & (rx_sub_q == SUB_MID);
  wire rx_end   = tick & (rx_sub_q == SUB_LAST);

  always_comb begin
    rx_state_d = rx_state_q;
    rx_done    = 1'b0;
    rb8_new    = ctrl_q[RB8_BIT];
    unique case (rx_state_q)
      ST_IDLE: begin
        if (rx_go_0) begin
          rx_state_d = ST_DATA;
        end else if (rx_go_a) begin
          rx_state_d = ST_START;
        end
      end
      ST_START: begin
        // A start bit that is high again at its middle was a glitch.
        if (rx_mid && serial_in_pin_i) begin
          rx_state_d = ST_IDLE;
        end else if (rx_end) begin
          rx_state_d = ST_DATA;
        end
      end
      ST_DATA: begin
        if (rx_end && rx_bit_q == LAST_DATA) begin
          unique case (mode)
            MODE_SHIFT: begin
              rx_state_d = ST_IDLE;
              rx_done    = 1'b1;
            end
            MODE_ASYNC8: rx_state_d = ST_STOP;
            default:     rx_state_d = ST_NINTH;
          endcase
        end
      end
      ST_NINTH: begin
        if (rx_end) begin
          rx_state_d = ST_STOP;
        end
      end
      ST_STOP: begin
        if (rx_mid) begin
          rx_state_d = ST_IDLE;
          rx_done    = 1'b1;
          rb8_new    = (mode == MODE_ASYNC8) ? serial_in_pin_i : ninth_q;
        end
      end
      default: rx_state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rx_state_q <= ST_IDLE;
      rx_sub_q   <= 4'h0;
      rx_bit_q   <= 3'h0;
      rx_sh_q    <= ZERO_BYTE;
      ninth_q    <= 1'b0;
    end else begin
      rx_state_q <= rx_state_d;
      rx_sub_q   <= rx_idle ? 4'h0 : (tick ? rx_sub_q + 4'h1 : rx_sub_q);
      if (rx_idle) begin
        rx_bit_q <= 3'h0;
      end else if (rx_end && rx_state_q == ST_DATA) begin
        rx_bit_q <= rx_bit_q + 3'h1;
      end
      if (rx_mid && rx_state_q == ST_DATA) begin
        rx_sh_q <= {serial_in_pin_i, rx_sh_q[7:1]};
      end
      if (rx_mid && rx_state_q == ST_NINTH) begin
        ninth_q <= serial_in_pin_i;
      end
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  always_comb begin
    ctrl_d = wr_ctrl ? reg_wdata_i : ctrl_q;
    if (rx_done && !m0) begin
      ctrl_d[RB8_BIT] = rb8_new;
    end
  end

  // ****************************************
  // Pins
  // ****************************************
  // The shift clock idles high and rises mid-bit, where data is sampled.
  wire m0_tx   = m0 & (tx_state_q == ST_DATA);
  wire m0_rx   = m0 & (rx_state_q == ST_DATA);
  wire shift_c = m0_tx ? tx_sub_q[SUB_CLK] : rx_sub_q[SUB_CLK];
  wire out_d   = m0 ? (~(m0_tx | m0_rx) | shift_c) : tx_line;

  // ****************************************
  // Register updates
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ctrl_q             <= CTRL_RESET;
      baud_q             <= BAUD_RESET;
      tip_q              <= 1'b0;
      rip_q              <= 1'b0;
      rxbuf_q            <= ZERO_BYTE;
      pre_q              <= 8'h00;
      reg_rdata_o        <= ZERO_BYTE;
      serial_in_pin_o    <= 1'b1;
      serial_in_pin_oe_o <= 1'b0;
      serial_out_pin_o   <= 1'b1;
      tx_fifo_ready_o    <= 1'b0;
      rx_irq_o           <= 1'b0;
      tx_irq_o           <= 1'b0;
    end else begin
      ctrl_q             <= ctrl_d;
      baud_q             <= wr_baud ? reg_wdata_i : baud_q;
      // Hardware set wins over a software clear in the same cycle.
      tip_q              <= tx_done | (wr_pend ? reg_wdata_i[TIP_BIT] : tip_q);
      rip_q              <= rx_done | (wr_pend ? reg_wdata_i[RIP_BIT] : rip_q);
      rxbuf_q            <= rx_done ? rx_sh_q : rxbuf_q;
      pre_q              <= tick ? 8'h00 : pre_q + 8'h01;
      reg_rdata_o        <= reg_rd_i ? rd_mux : ZERO_BYTE;
      serial_in_pin_o    <= m0_tx ? tx_sh_q[0] : 1'b1;
      serial_in_pin_oe_o <= m0_tx;
      serial_out_pin_o   <= out_d;
      tx_fifo_ready_o    <= fifo_ready;
      rx_irq_o           <= rip_q & ctrl_q[RIE_BIT];
      tx_irq_o           <= tip_q & ctrl_q[TIE_BIT];
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_reset_ctrl;
    @(posedge ref_clk_i) disable iff (1'b0) sys_rst_i |=> ctrl_q == CTRL_RESET;
  endproperty
  a_reset_ctrl: assert property (p_reset_ctrl) else $error("control not cleared");

  property p_tip_hold;
    tip_q && !wr_pend |=> tip_q;
  endproperty
  a_tip_hold: assert property (p_tip_hold) else $error("tx flag lost");

  property p_rip_hold;
    rip_q && !wr_pend |=> rip_q;
  endproperty
  a_rip_hold: assert property (p_rip_hold) else $error("rx flag lost");

  property p_stop_tip;
    tx_state_q == ST_STOP && $past(tx_state_q) != ST_STOP |-> tip_q;
  endproperty
  a_stop_tip: assert property (p_stop_tip) else $error("no tx flag at stop");

  property p_rx_mid;
    rx_state_q == ST_STOP && rx_mid |=> rip_q && rx_state_q == ST_IDLE;
  endproperty
  a_rx_mid: assert property (p_rx_mid) else $error("no rx flag mid stop");

  property p_m0_drive;
    m0_tx |=> serial_in_pin_oe_o && serial_in_pin_o == $past(tx_sh_q[0]);
  endproperty
  a_m0_drive: assert property (p_m0_drive) else $error("mode 0 data not driven");

  property p_start_low;
    tx_state_q == ST_START |=> !serial_out_pin_o;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low");

  property p_stop_high;
    tx_state_q == ST_STOP ##1 tx_state_q == ST_STOP |-> serial_out_pin_o;
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("stop bit not high");

  property p_ninth_bit;
    tx_state_q == ST_NINTH |=> serial_out_pin_o == $past(ctrl_q[TB8_BIT]);
  endproperty
  a_ninth_bit: assert property (p_ninth_bit) else $error("ninth bit wrong");

  property p_m0_gate;
    rx_idle && m0 && (rip_q || !rx_en) |=> rx_state_q == ST_IDLE;
  endproperty
  a_m0_gate: assert property (p_m0_gate) else $error("mode 0 rx started");

  property p_rx_irq;
    rip_q && ctrl_q[RIE_BIT] ##1 rip_q |-> rx_irq_o;
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("rx request missing");
endmodule

// *** core/uart_pkg.sv ***
// Purpose: Shared constants and types of the serial port.
// Assumes: One 8-bit register port, registers at fixed addresses.
// Notes:   Offsets, fields, reset values and oversampling counts.
package uart_pkg;
  // ****************************************
  // Register addresses and fields
  // ****************************************
  localparam logic [7:0] CTRL_ADDR  = 8'hfd;
  localparam logic [7:0] PEND_ADDR  = 8'hfe;
  localparam logic [7:0] DATA_ADDR  = 8'hff;
  localparam logic [7:0] BAUD_ADDR  = 8'hfc;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] BAUD_RESET = 8'h00;
  localparam logic [7:0] ZERO_BYTE  = 8'h00;
  localparam int MODE_HI  = 7;
  localparam int MODE_LO  = 6;
  localparam int RE_BIT   = 4;
  localparam int TB8_BIT  = 3;
  localparam int RB8_BIT  = 2;
  localparam int RIE_BIT  = 1;
  localparam int TIE_BIT  = 0;
  localparam int TIP_BIT  = 0;
  localparam int RIP_BIT  = 1;
  // ****************************************
  // Bit timing
  // ****************************************
  localparam logic [3:0] SUB_MID   = 4'h7;
  localparam logic [3:0] SUB_LAST  = 4'hf;
  localparam logic [2:0] LAST_DATA = 3'h7;
  localparam int         SUB_CLK   = 3;
  localparam int         FIFO_W    = 8;
  localparam int         FIFO_D    = 16;

  typedef enum logic [1:0] {
    MODE_SHIFT  = 2'b00,
    MODE_ASYNC8 = 2'b01,
    MODE_FIXED9 = 2'b10,
    MODE_VAR9   = 2'b11
  } mode_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_DATA  = 3'b010,
    ST_NINTH = 3'b011,
    ST_STOP  = 3'b100
  } shift_state_t;
endpackage

// *** core/uart_fifo.sv ***
// Purpose: Small synchronous FIFO with valid/ready on both sides.
// Assumes: Single clock, synchronous active-high reset.
// Notes:   Ready and valid come straight from flip-flops.
`timescale 1ns/1ps
module uart_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW:0] ONE_CNT  = (AW+1)'(1);
  localparam logic [AW:0] NO_CNT   = (AW+1)'(0);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  wire              push = in_valid_i & in_ready_o;
  wire              pop  = out_valid_o & out_ready_i;

  assign cnt_d = cnt_q + (push ? ONE_CNT : NO_CNT) - (pop ? ONE_CNT : NO_CNT);
  assign out_data_o = mem_q[rp_q];

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge ref_clk_i) begin
      if (push && wp_q == AW'(i)) begin
        mem_q[i] <= in_data_i;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      wp_q        <= '0;
      rp_q        <= '0;
      cnt_q       <= NO_CNT;
      in_ready_o  <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      wp_q        <= push ? wp_q + 1'b1 : wp_q;
      rp_q        <= pop ? rp_q + 1'b1 : rp_q;
      cnt_q       <= cnt_d;
      in_ready_o  <= cnt_d != FULL_CNT;
      out_valid_o <= cnt_d != NO_CNT;
    end
  end
endmodule

// *** sim/serial_partner.sv ***
// Purpose: Behavioural serial device on the far side of the port.
// Assumes: Async timing counted in ref_clk_i cycles, mode 0 paced by the shift clock; bit length given by the bench.
// Notes:   Receives async frames and mode 0 bytes, and sends both kinds.
`timescale 1ns/1ps
module serial_partner (
  input  wire logic        ref_clk_i,
  input  wire logic        tx_line_i,
  input  wire logic        pin_level_i,
  input  wire logic        shift_mode_i,
  input  wire logic [15:0] bit_clks_i,
  output logic             drive_o
);
  logic [7:0] rx_byte;
  logic [7:0] a_sh;
  logic [7:0] s_sh;
  logic       rx_stop;
  logic       in_stop;
  int         rx_count;
  int         shift_bits;

  initial begin
    drive_o    = 1'b1;
    in_stop    = 1'b0;
    rx_count   = 0;
    shift_bits = 0;
  end

  // ****************************************
  // Receivers
  // ****************************************
  // Sampling sits mid-bit, so a frame one clock off still decodes.
  always begin
    @(negedge tx_line_i);
    if (!shift_mode_i) begin
      repeat (bit_clks_i / 2) @(negedge ref_clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_clks_i) @(negedge ref_clk_i);
        a_sh[i] = tx_line_i;
      end
      repeat (bit_clks_i) @(negedge ref_clk_i);
      rx_stop  = tx_line_i;
      rx_byte  = a_sh;
      rx_count = rx_count + 1;
    end
  end

  always @(posedge tx_line_i) begin
    if (shift_mode_i) begin
      s_sh       = {pin_level_i, s_sh[7:1]};
      shift_bits = shift_bits + 1;
    end
  end

  // ****************************************
  // Senders
  // ****************************************
  task automatic send_async(input logic [7:0] b);
    @(negedge ref_clk_i) drive_o = 1'b0;
    repeat (bit_clks_i) @(negedge ref_clk_i);
    for (int i = 0; i < 8; i++) begin
      drive_o = b[i];
      repeat (bit_clks_i) @(negedge ref_clk_i);
    end
    drive_o = 1'b1;
    in_stop = 1'b1;
    repeat (bit_clks_i) @(negedge ref_clk_i);
    in_stop = 1'b0;
  endtask

  // Data moves on the falling clock edge after the rising shift clock, clear of sampling.
  task automatic send_shift(input logic [7:0] b);
    drive_o = b[0];
    for (int i = 1; i < 8; i++) begin
      @(posedge tx_line_i);
      @(negedge ref_clk_i);
      drive_o = b[i];
    end
    @(posedge tx_line_i);
    @(negedge ref_clk_i);
    drive_o = ~b[7];
  endtask
endmodule

// *** sim/serial_port_with_shift_mode_tb.sv ***
// Purpose: Self-checking bench of the serial port core.
// Assumes: Register strobes driven at the falling edge, one access at a time.
// Notes:   Mode 0 and mode 1 traffic, rates, flags and the transmit queue.
`timescale 1ns/1ps
module serial_port_with_shift_mode_tb;
  import uart_pkg::*;
  logic        ref_clk_i;
  logic        sys_rst_i;
  logic [7:0]  addr;
  logic        wr;
  logic        rd;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        pin_o;
  logic        pin_oe;
  logic        out_pin;
  logic        fifo_rdy;
  logic        rx_irq;
  logic        tx_irq;
  logic        p_drive;
  logic        shift_mode;
  logic [15:0] bit_clks;
  logic [7:0]  d;
  wire         pin_w = pin_oe ? pin_o : p_drive;
  int          mismatches;
  int          cmp_count;
  int          n;
  int          k;

  uart_core uut (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .serial_in_pin_i(pin_w),
    .serial_in_pin_o(pin_o), .serial_in_pin_oe_o(pin_oe), .serial_out_pin_o(out_pin),
    .tx_fifo_ready_o(fifo_rdy), .rx_irq_o(rx_irq), .tx_irq_o(tx_irq));

  serial_partner partner (
    .ref_clk_i(ref_clk_i), .tx_line_i(out_pin), .pin_level_i(pin_w),
    .shift_mode_i(shift_mode), .bit_clks_i(bit_clks), .drive_o(p_drive));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // The idle cycle lets the registered queue-ready flag catch up.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(negedge ref_clk_i);
    addr  = a;
    wdata = v;
    wr    = 1'b1;
    @(negedge ref_clk_i) wr = 1'b0;
    @(negedge ref_clk_i);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(negedge ref_clk_i);
    addr = a;
    rd   = 1'b1;
    @(negedge ref_clk_i) rd = 1'b0;
    v = rdata;
  endtask

  task automatic idle(input int c);
    repeat (c) @(negedge ref_clk_i);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    rd_reg(CTRL_ADDR, d); chk(d, 8'h00);
    rd_reg(BAUD_ADDR, d); chk(d, BAUD_RESET);
    rd_reg(8'hfb, d); chk(d, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_async_tx;
    shift_mode = 1'b0;
    bit_clks   = 16'd16;
    wr_reg(BAUD_ADDR, 8'h00);
    wr_reg(CTRL_ADDR, 8'h41);
    wr_reg(DATA_ADDR, 8'ha5);
    for (n = 0; n < 100 && out_pin !== 1'b0; n++) idle(1);
    for (n = 0; n < 400 && tx_irq !== 1'b1; n++) idle(1);
    chk(8'(n >= 142 && n <= 148), 8'h01);
    chk(out_pin, 1'b1);
    rd_reg(PEND_ADDR, d); chk(d, 8'h01);
    idle(200);
    chk(partner.rx_byte, 8'ha5);
    chk(partner.rx_stop, 1'b1);
    rd_reg(PEND_ADDR, d); chk(d, 8'h01);
    wr_reg(PEND_ADDR, 8'h00);
    chk(tx_irq, 1'b0);
    $display("test async transmit done");
  endtask

  task automatic t_async_rx;
    wr_reg(CTRL_ADDR, 8'h52);
    fork
      partner.send_async(8'h3c);
      begin
        wait (partner.in_stop === 1'b1);
        for (n = 0; n < 100 && rx_irq !== 1'b1; n++) @(negedge ref_clk_i);
      end
    join
    chk(8'(n >= 6 && n <= 10), 8'h01);
    rd_reg(DATA_ADDR, d); chk(d, 8'h3c);
    rd_reg(CTRL_ADDR, d); chk(d, 8'h56);
    rd_reg(PEND_ADDR, d); chk(d, 8'h02);
    partner.send_async(8'h11);
    partner.send_async(8'h22);
    rd_reg(DATA_ADDR, d); chk(d, 8'h22);
    wr_reg(PEND_ADDR, 8'h00);
    chk(rx_irq, 1'b0);
    $display("test async receive done");
  endtask

  task automatic t_rate;
    logic [7:0] m[4];
    int         e[4];
    m = '{8'h40, 8'h80, 8'hc0, 8'h00};
    e = '{48, 16, 48, 24};
    wr_reg(BAUD_ADDR, 8'h02);
    for (int i = 0; i < 4; i++) begin
      shift_mode = (i == 3);
      bit_clks   = (i == 1) ? 16'd16 : 16'd48;
      wr_reg(CTRL_ADDR, m[i]);
      wr_reg(DATA_ADDR, 8'h55);
      for (n = 0; n < 200 && out_pin !== 1'b0; n++) idle(1);
      for (n = 0; n < 200 && out_pin !== 1'b1; n++) idle(1);
      for (n = 0; n < 200 && out_pin === 1'b1; n++) idle(1);
      chk(8'(n), 8'(e[i]));
      idle(600);
      wr_reg(PEND_ADDR, 8'h00);
    end
    wr_reg(BAUD_ADDR, 8'h00);
    $display("test rates done");
  endtask

  task automatic t_shift_tx;
    shift_mode = 1'b1;
    partner.shift_bits = 0;
    wr_reg(CTRL_ADDR, 8'h01);
    wr_reg(DATA_ADDR, 8'h96);
    k = 0;
    for (n = 0; n < 400 && tx_irq !== 1'b1; n++) begin
      idle(1);
      if (pin_oe === 1'b1) k = 1;
    end
    chk(8'(k), 8'h01);
    chk(partner.s_sh, 8'h96);
    chk(8'(partner.shift_bits), 8'h08);
    rd_reg(PEND_ADDR, d); chk(d, 8'h01);
    wr_reg(PEND_ADDR, 8'h00);
    $display("test shift transmit done");
  endtask

  task automatic t_shift_rx;
    fork
      partner.send_shift(8'h4b);
      wr_reg(CTRL_ADDR, 8'h12);
    join
    for (n = 0; n < 400 && rx_irq !== 1'b1; n++) idle(1);
    chk(rx_irq, 1'b1);
    rd_reg(DATA_ADDR, d); chk(d, 8'h4b);
    k = 0;
    for (n = 0; n < 100; n++) begin
      idle(1);
      if (out_pin === 1'b0) k++;
    end
    chk(8'(k), 8'h00);
    wr_reg(PEND_ADDR, 8'h00);
    for (n = 0; n < 100 && out_pin !== 1'b0; n++) idle(1);
    chk(out_pin, 1'b0);
    wr_reg(CTRL_ADDR, 8'h00);
    idle(200);
    wr_reg(PEND_ADDR, 8'h00);
    $display("test shift receive done");
  endtask

  task automatic t_fifo;
    shift_mode = 1'b0;
    bit_clks   = 16'd16;
    wr_reg(CTRL_ADDR, 8'h40);
    partner.rx_count = 0;
    for (k = 0; k < 20 && fifo_rdy === 1'b1; k++) wr_reg(DATA_ADDR, 8'(k));
    chk(fifo_rdy, 1'b0);
    chk(8'(k >= FIFO_D && k <= FIFO_D + 1), 8'h01);
    idle(k * 170 + 200);
    chk(8'(partner.rx_count), 8'(k));
    chk(partner.rx_byte, 8'(k - 1));
    chk(fifo_rdy, 1'b1);
    $display("test transmit queue done");
  endtask

  // ****************************************
  // Run control
  // ****************************************
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  // The whole sequence needs about 7500 cycles; four times that is a hang.
  initial begin
    #3_000_000;
    mismatches++;
    print_verdict;
  end

  initial begin
    sys_rst_i  = 1'b1;
    addr       = 8'h00;
    wr         = 1'b0;
    rd         = 1'b0;
    wdata      = 8'h00;
    shift_mode = 1'b0;
    bit_clks   = 16'd16;
    mismatches = 0;
    cmp_count  = 0;
    idle(8);
    sys_rst_i = 1'b0;
    idle(2);
    t_reset;
    t_async_tx;
    t_async_rx;
    t_rate;
    t_shift_tx;
    t_shift_rx;
    t_fifo;
    print_verdict;
  end
endmodule
